// file: lps_pkg.sv
// Package for the low-power sleep sequencer and its core-side partner.
// Assumes a single 100 MHz system clock and a synchronous active-low reset.
package lps_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	// Regulator startup time from low-power mode, in ns
	localparam int unsigned REG_START_NS = 2000;
	localparam int unsigned REG_START_CYC =
		(REG_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Extra flash power-up time when flash was off, in ns
	localparam int unsigned FLASH_START_NS = 1000;
	localparam int unsigned FLASH_START_CYC =
		(FLASH_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 12;
	localparam logic [11:0] CNT_RESET = 12'h000;
	localparam int unsigned NUM_PERIPH = 8;
	localparam logic [7:0] CLK_EN_RESET = 8'h00;
	localparam logic [1:0] VRANGE_2 = 2'h2;
	localparam int unsigned PIN_W = 8;
	localparam logic [7:0] PIN_RESET = 8'h00;

	// One-bit steps run -> sleep -> waking; waking -> run flips both bits
	typedef enum logic [1:0] {
		LPS_RUN = 2'h0,
		LPS_SLEEP = 2'h1,
		LPS_WAKING = 2'h3
	} lps_state_type;

	typedef enum logic [1:0] {
		CORE_RUN = 2'h0,
		CORE_WAIT = 2'h1,
		CORE_RESUME = 2'h3
	} lps_core_state_type;
endpackage : lps_pkg

// file: lps_link_if.sv
// Interface between the sleep sequencer and the core-side partner.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
interface lps_link_if;
	logic wfi_pulse;
	logic wfe_pulse;
	logic isr_exit_pulse;
	logic deferred_sleep_flag;
	logic deep_state_select;
	logic event_on_pending_enable;
	logic regulator_lowpower_in_sleep;
	logic flash_off_in_sleep;
	logic [7:0] periph_run_en;
	logic [7:0] periph_sleep_en;
	logic [1:0] core_vrange;
	logic nested_interrupt_controller_irq_ack;
	logic pend_irq_masked;
	logic event_line;
	logic core_halt;
	logic in_lp_sleep;
	logic reg_main_ready;
	modport device (
		input wfi_pulse, wfe_pulse, isr_exit_pulse, deferred_sleep_flag,
		input deep_state_select, event_on_pending_enable,
		input regulator_lowpower_in_sleep, flash_off_in_sleep,
		input periph_run_en, periph_sleep_en, core_vrange,
		input nested_interrupt_controller_irq_ack, pend_irq_masked, event_line,
		output core_halt, in_lp_sleep, reg_main_ready
	);
	modport core (
		output wfi_pulse, wfe_pulse, isr_exit_pulse, deferred_sleep_flag,
		output deep_state_select, event_on_pending_enable,
		output regulator_lowpower_in_sleep, flash_off_in_sleep,
		output periph_run_en, periph_sleep_en, core_vrange,
		output nested_interrupt_controller_irq_ack, pend_irq_masked, event_line,
		input core_halt, in_lp_sleep, reg_main_ready
	);
endinterface : lps_link_if

// file: lps_pin_sync.sv
// Three-flop input synchroniser; output changes once flops two and three agree.
// Assumes sys_clk and a synchronous active-low reset.
`timescale 1ns/1ps
module lps_pin_sync (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic pin_in,
	output logic pin_out
);
	typedef struct packed {
		logic [2:0] stage;
		logic level;
	} lps_sync_type;
	lps_sync_type state_ff;
	lps_sync_type nxt_state;

	always_comb begin
		nxt_state = state_ff;
		nxt_state.stage = {state_ff.stage[1:0], pin_in};
		if (state_ff.stage[1] == state_ff.stage[2]) begin
			nxt_state.level = state_ff.stage[2];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign pin_out = state_ff.level;
endmodule : lps_pin_sync

// file: lps_sleep_ctrl.sv
// Low-power sleep sequencer: entry, wake sources, regulator and flash return.
// Assumes the core end drives the link on sys_clk; event_pin is asynchronous.
// Wake latency is counted in sys_clk cycles from package constants.
// Operation
// - Sleep needs low-power regulator plus wait
// - Flash blocked in sleep, RAM stays usable
// - Software keeps clock at or below range1
// - Software requests sleep only in range 2
// - Slow bus: read calendar twice, maybe thrice
// - Deferred clear: sleep at wait instruction
// - Deferred set: sleep on last handler exit
// - Immediate either wait; deferred needs wait-for-interrupt
// - Flash off in sleep lengthens wakeup
// - Sleep clock only with sleep enable
// - Lower clock, set regulator bit, wait last
// - Pins hold run-mode state in sleep
// - Wait-for-interrupt wakes on acknowledged interrupt
// - Wait-for-event wakes on any event
// - Masked pending interrupt wakes with send-on-pending
// - Event-mode line wakes without pending bit
// - Wake returns main regulator, then flash
// - Add regulator startup before resuming
`timescale 1ns/1ps
module lps_sleep_ctrl (
	input wire logic sys_clk,
	input wire logic reset_n,
	lps_link_if.device link,
	input wire logic event_pin,
	input wire logic [7:0] pin_drive,
	output logic [7:0] pin_out,
	output logic regulator_lowpower,
	output logic flash_powered,
	output logic flash_access_ok,
	output logic ram_access_ok,
	output logic [7:0] periph_clk_en,
	output logic event_line_pending
);
	// Whole sequencer state, registered as one word
	typedef struct packed {
		lps_pkg::lps_state_type st;
		logic by_wfe;
		logic flash_was_off;
		logic [11:0] cnt;
		logic reg_lp;
		logic flash_on;
		logic [7:0] pins;
		logic [7:0] clk_en;
		logic halt;
		logic main_ready;
		logic in_sleep;
		logic flash_ok;
		logic ram_ok;
		logic ev_pend;
	} lps_ctrl_type;
	lps_ctrl_type state_ff;
	lps_ctrl_type nxt_state;
	logic event_sync;
	logic entry_ok;
	logic now_entry;
	logic exit_entry;
	logic wake;
	wire [7:0] pin_next;

	// Event pin synchroniser
	lps_pin_sync u_event_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.pin_in(event_pin),
		.pin_out(event_sync)
	);

	// Clock gate: run enables, masked by sleep enables while asleep
	function automatic logic [7:0] lps_clk_gate(input logic sleeping,
		input logic [7:0] run_en, input logic [7:0] sleep_en);
		lps_clk_gate = sleeping ? (run_en & sleep_en) : run_en;
	endfunction : lps_clk_gate

	// Entry needs low-power regulator, shallow sleep and range 2
	function automatic logic lps_entry_ok(input logic lp_bit,
		input logic deep, input logic [1:0] vrange);
		lps_entry_ok = lp_bit && !deep
			&& (vrange == lps_pkg::VRANGE_2);
	endfunction : lps_entry_ok

	// Wake source depends on the wait kind that entered sleep
	function automatic logic lps_wake_hit(input logic from_wfe,
		input logic irq_ack, input logic sync_ev, input logic line_ev,
		input logic pend_en, input logic pend);
		if (from_wfe) begin
			lps_wake_hit = sync_ev || line_ev
				|| (pend_en && pend);
		end else begin
			lps_wake_hit = irq_ack;
		end
	endfunction : lps_wake_hit

	// Pins follow the drive only in run, otherwise hold
	for (genvar i = 0; i < lps_pkg::PIN_W; i++) begin : g_pin_hold
		assign pin_next[i] = (state_ff.st == lps_pkg::LPS_RUN)
			? pin_drive[i] : state_ff.pins[i];
	end

	// Entry and wake strobes
	always_comb begin
		entry_ok = lps_entry_ok(link.regulator_lowpower_in_sleep,
			link.deep_state_select, link.core_vrange);
		now_entry = entry_ok && !link.deferred_sleep_flag
			&& (link.wfi_pulse || link.wfe_pulse);
		exit_entry = entry_ok && link.deferred_sleep_flag
			&& link.isr_exit_pulse;
		wake = lps_wake_hit(state_ff.by_wfe, link.nested_interrupt_controller_irq_ack, event_sync,
			link.event_line, link.event_on_pending_enable,
			link.pend_irq_masked);
	end

	// Next-state logic
	always_comb begin
		nxt_state = state_ff;
		case (state_ff.st)
			lps_pkg::LPS_RUN: begin
				nxt_state.pins = pin_next;
				nxt_state.clk_en = lps_clk_gate(1'b0, link.periph_run_en,
					link.periph_sleep_en);
				if (now_entry || exit_entry) begin
					nxt_state.st = lps_pkg::LPS_SLEEP;
					nxt_state.by_wfe = now_entry && link.wfe_pulse
						&& !link.wfi_pulse;
					nxt_state.halt = 1'b1;
					nxt_state.main_ready = 1'b0;
					nxt_state.reg_lp = 1'b1;
					nxt_state.flash_was_off = link.flash_off_in_sleep;
					nxt_state.flash_on = !link.flash_off_in_sleep;
					nxt_state.clk_en = lps_clk_gate(1'b1, link.periph_run_en,
						link.periph_sleep_en);
				end
			end
			// Sleep holds until a wake source of the entry kind
			lps_pkg::LPS_SLEEP: begin
				nxt_state.clk_en = lps_clk_gate(1'b1, link.periph_run_en,
					link.periph_sleep_en);
				if (wake) begin
					nxt_state.st = lps_pkg::LPS_WAKING;
					nxt_state.reg_lp = 1'b0;
					nxt_state.cnt = state_ff.flash_was_off
						? 12'(lps_pkg::REG_START_CYC
						+ lps_pkg::FLASH_START_CYC)
						: 12'(lps_pkg::REG_START_CYC);
				end
			end
			// Regulator leg, then flash leg, then halt release
			lps_pkg::LPS_WAKING: begin
				if (state_ff.cnt == 12'(lps_pkg::FLASH_START_CYC)) begin
					nxt_state.flash_on = 1'b1;
				end
				if (state_ff.cnt > lps_pkg::CNT_RESET) begin
					nxt_state.cnt = state_ff.cnt - 12'h0001;
				end else begin
					nxt_state.flash_on = 1'b1;
					nxt_state.halt = 1'b0;
					nxt_state.main_ready = 1'b1;
					nxt_state.st = lps_pkg::LPS_RUN;
					nxt_state.clk_en = link.periph_run_en;
				end
			end
			default: nxt_state.st = lps_pkg::LPS_RUN;
		endcase
		// Status bits registered so every output leaves a flop
		nxt_state.in_sleep = (nxt_state.st == lps_pkg::LPS_SLEEP);
		nxt_state.flash_ok = (nxt_state.st == lps_pkg::LPS_RUN);
		nxt_state.ram_ok = 1'b1;
		nxt_state.ev_pend = 1'b0;
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_ff.st <= lps_pkg::LPS_RUN;
			state_ff.by_wfe <= 1'b0;
			state_ff.flash_was_off <= 1'b0;
			state_ff.cnt <= lps_pkg::CNT_RESET;
			state_ff.reg_lp <= 1'b0;
			state_ff.flash_on <= 1'b1;
			state_ff.pins <= lps_pkg::PIN_RESET;
			state_ff.clk_en <= lps_pkg::CLK_EN_RESET;
			state_ff.halt <= 1'b0;
			state_ff.main_ready <= 1'b1;
			state_ff.in_sleep <= 1'b0;
			state_ff.flash_ok <= 1'b1;
			state_ff.ram_ok <= 1'b1;
			state_ff.ev_pend <= 1'b0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Outputs
	assign pin_out = state_ff.pins;
	assign regulator_lowpower = state_ff.reg_lp;
	assign flash_powered = state_ff.flash_on;
	assign flash_access_ok = state_ff.flash_ok;
	assign ram_access_ok = state_ff.ram_ok;
	assign periph_clk_en = state_ff.clk_en;
	assign event_line_pending = state_ff.ev_pend;
	assign link.core_halt = state_ff.halt;
	assign link.in_lp_sleep = state_ff.in_sleep;
	assign link.reg_main_ready = state_ff.main_ready;
endmodule : lps_sleep_ctrl

// file: lps_core_end.sv
// Core-side partner: sets controls in order, issues waits, clears pendings.
// Assumes the sequencer end on the same sys_clk.
`timescale 1ns/1ps
module lps_core_end (
	input wire logic sys_clk,
	input wire logic reset_n,
	lps_link_if.core link,
	input wire logic sleep_req,
	input wire logic use_wfe,
	input wire logic deferred,
	input wire logic flash_off,
	input wire logic send_on_pend,
	input wire logic [7:0] run_en,
	input wire logic [7:0] sleep_en,
	input wire logic irq_ack,
	input wire logic masked_pend,
	input wire logic ev_line,
	output logic clk_slow,
	output logic clk_fast_ok,
	output logic clear_pendings,
	output logic busy
);
	typedef struct packed {
		lps_pkg::lps_core_state_type st;
		logic [1:0] step;
		logic slow;
		logic lp_bit;
		logic wait_for_interrupt_instr;
		logic wait_for_event_instr;
		logic isr_exit;
		logic woke_by_pend;
		logic clr;
		logic fast_ok;
		logic bsy;
	} lps_core_type;
	lps_core_type state_ff;
	lps_core_type nxt_state;

	always_comb begin
		nxt_state = state_ff;
		nxt_state.wait_for_interrupt_instr = 1'b0;
		nxt_state.wait_for_event_instr = 1'b0;
		nxt_state.isr_exit = 1'b0;
		nxt_state.clr = 1'b0;
		case (state_ff.st)
			lps_pkg::CORE_RUN: begin
				if (sleep_req) begin
					nxt_state.fast_ok = 1'b0;
					nxt_state.slow = 1'b1;
					nxt_state.step = 2'h0;
					nxt_state.st = lps_pkg::CORE_WAIT;
				end
			end
			lps_pkg::CORE_WAIT: begin
				if (state_ff.step == 2'h0) begin
					nxt_state.lp_bit = 1'b1;
					nxt_state.step = 2'h1;
				end else if (state_ff.step == 2'h1) begin
					if (deferred) begin
						nxt_state.wait_for_interrupt_instr = 1'b1;
						nxt_state.isr_exit = 1'b1;
					end else begin
						nxt_state.wait_for_event_instr = use_wfe;
						nxt_state.wait_for_interrupt_instr = !use_wfe;
					end
					nxt_state.woke_by_pend = use_wfe && !deferred
						&& send_on_pend;
					nxt_state.step = 2'h2;
				end else if (link.core_halt) begin
					nxt_state.st = lps_pkg::CORE_RESUME;
				end else if (state_ff.step == 2'h2) begin
					nxt_state.step = 2'h3;
				end else begin
					nxt_state.st = lps_pkg::CORE_RUN;
					nxt_state.lp_bit = 1'b0;
					nxt_state.slow = 1'b0;
					nxt_state.fast_ok = 1'b1;
				end
			end
			lps_pkg::CORE_RESUME: begin
				if (!link.core_halt && link.reg_main_ready) begin
					nxt_state.lp_bit = 1'b0;
					nxt_state.slow = 1'b0;
					nxt_state.fast_ok = 1'b1;
					nxt_state.clr = state_ff.woke_by_pend;
					nxt_state.st = lps_pkg::CORE_RUN;
				end
			end
			default: nxt_state.st = lps_pkg::CORE_RUN;
		endcase
		nxt_state.bsy = (nxt_state.st != lps_pkg::CORE_RUN);
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_ff <= '0;
			state_ff.fast_ok <= 1'b1;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign link.wfi_pulse = state_ff.wait_for_interrupt_instr;
	assign link.wfe_pulse = state_ff.wait_for_event_instr;
	assign link.isr_exit_pulse = state_ff.isr_exit;
	assign link.deferred_sleep_flag = deferred;
	assign link.deep_state_select = 1'b0;
	assign link.event_on_pending_enable = send_on_pend;
	assign link.regulator_lowpower_in_sleep = state_ff.lp_bit;
	assign link.flash_off_in_sleep = flash_off;
	assign link.periph_run_en = run_en;
	assign link.periph_sleep_en = sleep_en;
	assign link.core_vrange = lps_pkg::VRANGE_2;
	assign link.nested_interrupt_controller_irq_ack = irq_ack;
	assign link.pend_irq_masked = masked_pend;
	assign link.event_line = ev_line;
	assign clk_slow = state_ff.slow;
	assign clk_fast_ok = state_ff.fast_ok;
	assign clear_pendings = state_ff.clr;
	assign busy = state_ff.bsy;
endmodule : lps_core_end

// file: lps_sleep_assertions.sv
// Checker on the sleep link between sequencer and core end.
// Assumes one sys_clk domain and a synchronous active-low reset.
`timescale 1ns/1ps
module lps_sleep_assertions (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic wfi_pulse,
	input wire logic wfe_pulse,
	input wire logic isr_exit_pulse,
	input wire logic deferred_sleep_flag,
	input wire logic deep_state_select,
	input wire logic event_on_pending_enable,
	input wire logic regulator_lowpower_in_sleep,
	input wire logic [1:0] core_vrange,
	input wire logic nested_interrupt_controller_irq_ack,
	input wire logic pend_irq_masked,
	input wire logic event_line,
	input wire logic core_halt,
	input wire logic in_lp_sleep,
	input wire logic reg_main_ready
);
	localparam int WAKE_MIN = lps_pkg::REG_START_CYC;
	logic by_wfe_ff;
	logic [11:0] wait_cnt_ff;
	wire ok = regulator_lowpower_in_sleep & !deep_state_select &
		(core_vrange == lps_pkg::VRANGE_2) & !core_halt;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// Remembers which wait kind entered sleep; counts waking cycles
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			by_wfe_ff <= 1'b0;
			wait_cnt_ff <= 12'h000;
		end else begin
			if (!core_halt & (wfi_pulse | wfe_pulse | isr_exit_pulse))
				by_wfe_ff <= wfe_pulse;
			wait_cnt_ff <= (core_halt & !in_lp_sleep) ? wait_cnt_ff + 12'h001
				: 12'h000;
		end
	end
	AST_ENTRY_NOW: assert property (ok & !deferred_sleep_flag &
		(wfi_pulse | wfe_pulse) |=> in_lp_sleep & core_halt)
		else $error("no sleep after wait");
	AST_ENTRY_EXIT: assert property (ok & deferred_sleep_flag &
		isr_exit_pulse |=> in_lp_sleep) else $error("no deferred sleep");
	AST_NEED_LP: assert property (!regulator_lowpower_in_sleep &
		!core_halt |=> !in_lp_sleep) else $error("sleep without lp bit");
	AST_REFUSE: assert property (!core_halt & (deep_state_select |
		deferred_sleep_flag & !isr_exit_pulse) |=> !in_lp_sleep)
		else $error("illegal sleep entry");
	AST_WFI_WAKE: assert property (in_lp_sleep & !by_wfe_ff &
		nested_interrupt_controller_irq_ack |=> !in_lp_sleep) else $error("no interrupt wake");
	AST_WFI_HOLD: assert property (in_lp_sleep & !by_wfe_ff &
		!nested_interrupt_controller_irq_ack |=> in_lp_sleep) else $error("spurious wake");
	AST_WFE_WAKE: assert property (in_lp_sleep & by_wfe_ff &
		(event_line | event_on_pending_enable & pend_irq_masked)
		|=> !in_lp_sleep) else $error("no event wake");
	AST_WAKE_BOUND: assert property ($fell(in_lp_sleep) |->
		##[1:320] $fell(core_halt)) else $error("wake too long");
	AST_WAKE_MIN: assert property ($fell(core_halt) |->
		wait_cnt_ff >= WAKE_MIN) else $error("wake too short");
	AST_READY: assert property ($fell(core_halt) |-> reg_main_ready)
		else $error("halt released before ready");
	AST_READY_LOW: assert property (in_lp_sleep |-> !reg_main_ready)
		else $error("main regulator ready in sleep");
endmodule : lps_sleep_assertions

// file: lps_sleep_ctrl_tb.sv
// Testbench joining sequencer and core end through the link interface.
// Assumes lps_pkg, lps_link_if and both design ends are compiled first.
`timescale 1ns/1ps
module lps_sleep_ctrl_tb;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic sleep_req = 0, use_wfe = 0, deferred = 0, flash_off = 0;
	logic send_on_pend = 0, irq_ack = 0, masked_pend = 0, ev_line = 0;
	logic event_pin = 0, cp_seen = 0;
	logic [7:0] run_en = 8'hF0, sleep_en = 8'h3C, pin_drive = 8'hA5;
	logic [7:0] pin_out, periph_clk_en;
	logic regulator_lowpower, flash_powered, flash_access_ok, ram_access_ok;
	logic event_line_pending, clk_slow, clk_fast_ok, clear_pendings, busy;
	int errors = 0;
	int check_count = 0;
	lps_link_if link();
	lps_sleep_ctrl lps_sleep_ctrl_inst (.sys_clk(sys_clk), .reset_n(reset_n),
		.link(link), .event_pin(event_pin), .pin_drive(pin_drive),
		.pin_out(pin_out), .regulator_lowpower(regulator_lowpower),
		.flash_powered(flash_powered), .flash_access_ok(flash_access_ok),
		.ram_access_ok(ram_access_ok), .periph_clk_en(periph_clk_en),
		.event_line_pending(event_line_pending));
	lps_core_end lps_core_end_inst (.sys_clk(sys_clk), .reset_n(reset_n),
		.link(link), .sleep_req(sleep_req), .use_wfe(use_wfe),
		.deferred(deferred), .flash_off(flash_off),
		.send_on_pend(send_on_pend), .run_en(run_en), .sleep_en(sleep_en),
		.irq_ack(irq_ack), .masked_pend(masked_pend), .ev_line(ev_line),
		.clk_slow(clk_slow), .clk_fast_ok(clk_fast_ok),
		.clear_pendings(clear_pendings), .busy(busy));
	lps_sleep_assertions lps_sleep_assertions_inst (.sys_clk(sys_clk),
		.reset_n(reset_n), .wfi_pulse(link.wfi_pulse),
		.wfe_pulse(link.wfe_pulse), .isr_exit_pulse(link.isr_exit_pulse),
		.deferred_sleep_flag(link.deferred_sleep_flag),
		.deep_state_select(link.deep_state_select),
		.event_on_pending_enable(link.event_on_pending_enable),
		.regulator_lowpower_in_sleep(link.regulator_lowpower_in_sleep),
		.core_vrange(link.core_vrange), .nested_interrupt_controller_irq_ack(link.nested_interrupt_controller_irq_ack),
		.pend_irq_masked(link.pend_irq_masked), .event_line(link.event_line),
		.core_halt(link.core_halt), .in_lp_sleep(link.in_lp_sleep),
		.reg_main_ready(link.reg_main_ready));
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (clear_pendings === 1'b1)
			cp_seen <= 1'b1;
	end
	task automatic summarize;
		if (errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: bit %b not %b", $time, got, exp);
		end
	endtask : chk_bit
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: byte %h not %h", $time, got, exp);
		end
	endtask : chk_byte
	// Waits at falling edges for a link or core signal, bounded
	task automatic wait_on(input int sel, input logic v, input int lim,
		output int n);
		logic s;
		n = 0;
		forever begin
			s = (sel == 0) ? link.in_lp_sleep : (sel == 1) ? link.core_halt : busy;
			if (s === v)
				return;
			if (n == lim) begin
				errors++;
				$display("mismatch at %0t: wait timed out", $time);
				summarize();
			end
			@(negedge sys_clk);
			n++;
		end
	endtask : wait_on
	// One sleep cycle; src 0 irq, 1 event line, 2 masked pend, 3 event pin
	task automatic run(input logic wait_for_event_instr, fl, sop, defr, input int src);
		int n;
		int lo;
		logic [7:0] p;
		@(negedge sys_clk);
		{use_wfe, flash_off, send_on_pend, deferred} = {wait_for_event_instr, fl, sop, defr};
		sleep_req = 1'b1;
		wait_on(0, 1'b1, 40, n);
		sleep_req = 1'b0;
		chk_bit(link.core_halt, 1'b1);
		chk_bit(regulator_lowpower, 1'b1);
		chk_bit(flash_powered, !fl);
		chk_bit(flash_access_ok, 1'b0);
		chk_bit(ram_access_ok, 1'b1);
		chk_byte(periph_clk_en, run_en & sleep_en);
		p = pin_drive;
		pin_drive = ~p;
		{ev_line, event_pin} = {!wait_for_event_instr, !wait_for_event_instr};
		repeat (6) @(negedge sys_clk);
		chk_byte(pin_out, p);
		chk_bit(link.in_lp_sleep, 1'b1);
		cp_seen = 1'b0;
		irq_ack = (src == 0);
		ev_line = (src == 1);
		masked_pend = (src == 2);
		event_pin = (src == 3);
		wait_on(1, 1'b0, 400, n);
		lo = lps_pkg::REG_START_CYC + 1 + (fl ? lps_pkg::FLASH_START_CYC : 0);
		chk_bit(n >= lo && n <= lo + 6, 1'b1);
		chk_bit(regulator_lowpower, 1'b0);
		chk_bit(link.reg_main_ready, 1'b1);
		{irq_ack, ev_line, masked_pend, event_pin} = 4'h0;
		wait_on(2, 1'b0, 20, n);
		repeat (2) @(negedge sys_clk);
		chk_bit(clk_fast_ok, 1'b1);
		chk_bit(flash_access_ok, 1'b1);
		chk_byte(pin_out, ~p);
		chk_byte(periph_clk_en, run_en);
		chk_bit(event_line_pending, 1'b0);
		if (src == 2)
			chk_bit(cp_seen, 1'b1);
	endtask : run
	initial begin
		repeat (8) @(negedge sys_clk);
		reset_n = 1'b1;
		chk_bit(link.core_halt, 1'b0);
		chk_bit(link.reg_main_ready, 1'b1);
		run(1'b0, 1'b0, 1'b0, 1'b0, 0);
		run(1'b1, 1'b1, 1'b0, 1'b0, 1);
		run(1'b1, 1'b0, 1'b1, 1'b0, 2);
		run(1'b1, 1'b0, 1'b0, 1'b0, 3);
		run(1'b0, 1'b1, 1'b0, 1'b1, 0);
		summarize();
	end
endmodule : lps_sleep_ctrl_tb
